// ==== shared/adc_seq_pkg.sv ====
// constants, register map and enumerations for the oversampling conversion sequencer
// assumes a single 40 MHz clock and a plain strobe register port
package adc_seq_pkg;
  // register word addresses (index space of the plain port)
  localparam logic [3:0] ADDR_CFG1    = 4'h0; // analog config: ratio and count codes
  localparam logic [3:0] ADDR_CFG2    = 4'h1; // analog config: bias selects
  localparam logic [3:0] ADDR_CFG3    = 4'h2; // analog config: gain stage enables
  localparam logic [3:0] ADDR_CFG4    = 4'h3; // analog config: free storage
  localparam logic [3:0] ADDR_CFG5    = 4'h4; // analog config: input channel
  localparam logic [3:0] ADDR_CTRL    = 4'h5; // start command, clock divider
  localparam logic [3:0] ADDR_STATUS  = 4'h6; // busy, resolution, settle state
  localparam int         NUM_CFG      = 5;    // count of analog config registers
  // field positions
  localparam int OSR_LSB   = 0;  // 3-bit ratio code, ratio = 8 << code
  localparam int NEL_LSB   = 4;  // 2-bit count code, count = 1 << code
  localparam int AMPB_LSB  = 0;  // amplifier bias select
  localparam int CONVB_LSB = 2;  // converter bias select
  localparam int START_BIT = 0;  // start bit in control
  localparam int DIV_LSB   = 8;  // oversampling clock divider field
  // reset values
  localparam logic [7:0]  CFG_RST    = 8'h00;
  localparam logic [7:0]  BIAS_RST   = 8'h0F;  // full bias on both
  localparam logic [7:0]  DIV_RST    = 8'h27;  // divide by 40 -> 1 MHz tick
  // encoding limits
  localparam logic [2:0]  OSR_CODE_MAX = 3'h7; // 8 << 7 = 1024
  localparam logic [10:0] OSR_BASE     = 11'h008;
  localparam logic [3:0]  RES_BASE     = 4'h6;  // 2*log2(8)
  // bias codes and their fraction of nominal in quarters
  localparam logic [1:0] BIAS_FULL = 2'h3;
  localparam logic [1:0] BIAS_3Q   = 2'h2;
  localparam logic [1:0] BIAS_HALF = 2'h1;
  localparam logic [1:0] BIAS_1Q   = 2'h0;
  localparam logic [2:0] QTR_4 = 3'h4;
  localparam logic [2:0] QTR_3 = 3'h3;
  localparam logic [2:0] QTR_2 = 3'h2;
  localparam logic [2:0] QTR_1 = 3'h1;
  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_CONV = 3'b010,
    ST_DONE = 3'b100
  } seq_state_e;
endpackage : adc_seq_pkg

// ==== hdl/fs_tick_gen.sv ====
// oversampling clock enable generator
// assumes a divider value written by software; produces a one-cycle tick
`timescale 1ns/100ps
module fs_tick_gen
  import adc_seq_pkg::*;
(
  input  wire logic       ref_clk_in, // system clock
  input  wire logic       rst_b_in,   // async reset, active low
  input  wire logic [7:0] div_in,     // divide value minus one
  input  wire logic       sync_in,    // restart the divider
  output logic            tick_out    // one pulse per oversampling period
);
  logic [7:0] cnt;       // divider count
  logic [7:0] next_cnt;  // next divider count
  logic       next_tick; // next tick value

  //////////////////////////////////////////////////////////////////////////////
  // next-state of the divider
  always_comb begin
    next_cnt  = cnt + 8'h01;
    next_tick = 1'b0;
    if (sync_in) begin          // restart phase on a new conversion
      next_cnt = 8'h00;
    end else if (cnt >= div_in) begin
      next_cnt  = 8'h00;
      next_tick = 1'b1;
    end
  end

  // register the divider
  always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      cnt      <= 8'h00;
      tick_out <= 1'b0;
    end else begin
      cnt      <= next_cnt;
      tick_out <= next_tick;
    end
  end
endmodule : fs_tick_gen

// ==== hdl/oversampling_adc_sequencer.sv ====
// conversion sequencer: config registers, start, length counter, ready pulse
// assumes synchronous host strobes on a plain port, read data one cycle later
//
// Our own choices: strobed register access and the address map.
`timescale 1ns/100ps
// Behaviour
// R1 - ratio only powers of two 8 to 1024
// R2 - elementary count only 1, 2, 4, 8
// R3 - resolution is twice log2 ratio plus log2 count
// R4 - length count*(ratio+1)+1 oversampling periods
// R5 - config write resets gain stages
// R6 - host waits ratio cycles before starting
// R7 - start bit write launches a conversion
// R8 - no wait needed when stages bypassed
// R9 - bias codes map to quarter fractions
// R10 - one-period ready pulse at conversion end
// R11 - length counter on oversampling clock, cleared at start
module oversampling_adc_sequencer
  import adc_seq_pkg::*;
(
  input  wire logic       ref_clk_in,       // 40 MHz clock
  input  wire logic       rst_b_in,         // async reset, active low
  input  wire logic [3:0] addr_in,          // register address
  input  wire logic [15:0] wdata_in,        // write data
  input  wire logic       wr_in,            // write strobe
  input  wire logic       rd_in,            // read strobe
  output logic [15:0]     rdata_out,        // read data, cycle after rd_in
  output logic            gain_reset_out,   // one-cycle gain stage reset
  output logic            busy_out,         // conversion running
  output logic            ready_out,        // end-of-conversion pulse
  output logic [2:0]      amp_bias_qtr_out, // amplifier bias in quarters
  output logic [2:0]      conv_bias_qtr_out,// converter bias in quarters
  output logic [4:0]      resolution_out,   // result width in bits
  output logic [2:0]      stage_en_out      // gain stage enables
);
  logic [7:0]  analog_config_regs [NUM_CFG]; // five analog config words
  logic [7:0]  next_cfg [NUM_CFG];            // next config words
  logic [7:0]  div;                           // oversampling divider
  logic [7:0]  next_div;
  logic        fs_tick;                       // oversampling clock enable
  logic        start_acc;                     // accepted start this cycle
  seq_state_e  state;                         // sequencer state
  seq_state_e  next_state;
  logic [13:0] len_cnt;                       // length counter in fs periods
  logic [13:0] next_len_cnt;
  logic [13:0] conv_len;                      // latched conversion length
  logic [13:0] next_conv_len;
  logic [10:0] settle_cnt;                    // fs periods since last config write
  logic [10:0] next_settle_cnt;
  logic [15:0] next_rdata;
  logic        next_gain_reset;
  logic        next_ready;
  logic [2:0]  oversampling_ratio_code;       // ratio code, raw 3-bit field
  logic [1:0]  elementary_conversion_count_code;
  logic [10:0] oversampling_ratio;            // ratio value
  logic [3:0]  elementary_conversion_count;   // count value
  logic [13:0] calc_len;                      // length for current settings
  logic [4:0]  calc_res;                      // resolution for current settings
  logic        settled;                       // settle delay elapsed
  logic [1:0]  amp_bias_current_sel;
  logic [1:0]  converter_bias_current_sel;

  //////////////////////////////////////////////////////////////////////////////
  // decode of the config fields
  always_comb begin
    oversampling_ratio_code = analog_config_regs[0][OSR_LSB +: 3]; // [R1]
    elementary_conversion_count_code = analog_config_regs[0][NEL_LSB +: 2]; // [R2]
    // power-of-two ratio from a 3-bit code: only 8..1024 reachable
    oversampling_ratio = OSR_BASE << oversampling_ratio_code; // [R1]
    elementary_conversion_count = 4'h1 << elementary_conversion_count_code; // [R2]
    // resolution = 2*log2(ratio) + log2(count)
    calc_res = 5'(RES_BASE) + 5'({oversampling_ratio_code, 1'b0})
             + 5'(elementary_conversion_count_code); // [R3]
    // length = count*(ratio+1) + 1, count as shift
    calc_len = 14'((14'(oversampling_ratio) + 14'h0001)
             << elementary_conversion_count_code) + 14'h0001; // [R4]
    amp_bias_current_sel       = analog_config_regs[1][AMPB_LSB +: 2];
    converter_bias_current_sel = analog_config_regs[1][CONVB_LSB +: 2];
    // settle delay is ratio periods; bypassed stages need none
    settled = (settle_cnt >= oversampling_ratio)
           || (analog_config_regs[2][2:0] == 3'h0); // [R6] [R8]
  end

  // bias select to quarter fraction
  function automatic logic [2:0] bias_qtr(input logic [1:0] sel);
    case (sel)
      BIAS_FULL: bias_qtr = QTR_4; // [R9]
      BIAS_3Q:   bias_qtr = QTR_3; // [R9]
      BIAS_HALF: bias_qtr = QTR_2; // [R9]
      BIAS_1Q:   bias_qtr = QTR_1; // [R9]
      default:   bias_qtr = QTR_4;
    endcase
  endfunction : bias_qtr

  //////////////////////////////////////////////////////////////////////////////
  // oversampling clock enable
  fs_tick_gen u_fs_tick (
    .ref_clk_in (ref_clk_in),
    .rst_b_in   (rst_b_in),
    .div_in     (div),
    .sync_in    (start_acc),
    .tick_out   (fs_tick)
  );

  //////////////////////////////////////////////////////////////////////////////
  // register file next values
  always_comb begin
    for (int i = 0; i < NUM_CFG; i++) begin
      next_cfg[i] = analog_config_regs[i];
    end
    next_div        = div;
    next_gain_reset = 1'b0;
    start_acc       = 1'b0;
    if (wr_in) begin
      if (addr_in < 4'(NUM_CFG)) begin // any analog config write
        next_cfg[addr_in[2:0]] = wdata_in[7:0];
        next_gain_reset = 1'b1; // [R5]
      end else if (addr_in == ADDR_CTRL) begin
        next_div  = wdata_in[DIV_LSB +: 8];
        // start accepted only when idle
        start_acc = wdata_in[START_BIT] && (state == ST_IDLE); // [R7]
      end
    end
    // read mux
    next_rdata = 16'h0000;
    if (rd_in) begin
      if (addr_in < 4'(NUM_CFG)) begin
        next_rdata = {8'h00, analog_config_regs[addr_in[2:0]]};
      end else if (addr_in == ADDR_CTRL) begin
        next_rdata = {div, 8'h00};
      end else if (addr_in == ADDR_STATUS) begin
        next_rdata = {9'h000, calc_res, settled, busy_out};
      end else begin
        next_rdata = 16'h0000; // unmapped reads zero
      end
    end
  end

  // settle counter: cleared by config write, saturates
  always_comb begin
    next_settle_cnt = settle_cnt;
    if (next_gain_reset) begin
      next_settle_cnt = 11'h000;
    end else if (fs_tick && !settle_cnt[10]) begin
      next_settle_cnt = settle_cnt + 11'h001;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // sequencer next-state
  always_comb begin
    next_state    = state;
    next_len_cnt  = len_cnt;
    next_conv_len = conv_len;
    next_ready    = 1'b0;
    case (state)
      ST_IDLE: begin
        if (start_acc) begin
          next_len_cnt  = 14'h0000; // [R11]
          next_conv_len = calc_len; // [R4]
          next_state    = ST_CONV;
        end
      end
      ST_CONV: begin
        if (fs_tick) begin // count oversampling periods [R11]
          next_len_cnt = len_cnt + 14'h0001;
          if (len_cnt + 14'h0001 >= conv_len) begin
            next_state = ST_DONE; // [R4]
            next_ready = 1'b1;    // [R10]
          end
        end
      end
      ST_DONE: begin
        // ready held for one full fs period
        next_ready = 1'b1; // [R10]
        if (fs_tick) begin
          next_ready = 1'b0;
          next_state = ST_IDLE;
        end
      end
      default: begin
        next_state = ST_IDLE;
      end
    endcase
  end

  //////////////////////////////////////////////////////////////////////////////
  // register everything
  always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      analog_config_regs[0] <= CFG_RST;
      analog_config_regs[1] <= BIAS_RST;
      analog_config_regs[2] <= CFG_RST;
      analog_config_regs[3] <= CFG_RST;
      analog_config_regs[4] <= CFG_RST;
      div               <= DIV_RST;
      state             <= ST_IDLE;
      len_cnt           <= 14'h0000;
      conv_len          <= 14'h0000;
      settle_cnt        <= 11'h000;
      rdata_out         <= 16'h0000;
      gain_reset_out    <= 1'b0;
      busy_out          <= 1'b0;
      ready_out         <= 1'b0;
      amp_bias_qtr_out  <= QTR_4;
      conv_bias_qtr_out <= QTR_4;
      resolution_out    <= 5'(RES_BASE);
      stage_en_out      <= 3'h0;
    end else begin
      for (int i = 0; i < NUM_CFG; i++) begin
        analog_config_regs[i] <= next_cfg[i];
      end
      div               <= next_div;
      state             <= next_state;
      len_cnt           <= next_len_cnt;
      conv_len          <= next_conv_len;
      settle_cnt        <= next_settle_cnt;
      rdata_out         <= next_rdata;
      gain_reset_out    <= next_gain_reset; // [R5]
      busy_out          <= (next_state == ST_CONV);
      ready_out         <= next_ready; // [R10]
      amp_bias_qtr_out  <= bias_qtr(amp_bias_current_sel); // [R9]
      conv_bias_qtr_out <= bias_qtr(converter_bias_current_sel); // [R9]
      resolution_out    <= calc_res; // [R3]
      stage_en_out      <= analog_config_regs[2][2:0];
    end
  end
endmodule : oversampling_adc_sequencer

// ==== tb/host_model.sv ====
// host side model: register port master that also keeps the settle wait
// assumes the sequencer takes strobes at the rising clock edge
`timescale 1ns/100ps
module host_model
  import adc_seq_pkg::*;
(
  input  wire logic   clk_in,    // system clock
  output logic [3:0]  addr_out,  // register address
  output logic [15:0] wdata_out, // write data
  output logic        wr_out,    // write strobe
  output logic        rd_out     // read strobe
);
  // idle bus at time zero
  initial begin
    addr_out  = 4'h0;
    wdata_out = 16'h0000;
    wr_out    = 1'b0;
    rd_out    = 1'b0;
  end
  // one-cycle write; released data is scrambled so nothing leans on it
  task automatic wr_reg(input logic [3:0] a, input logic [15:0] d);
    @(posedge clk_in);
    addr_out  <= a;
    wdata_out <= d;
    wr_out    <= 1'b1;
    @(posedge clk_in);
    wr_out    <= 1'b0;
    wdata_out <= ~d;
  endtask : wr_reg
  // one-cycle read; data is picked up by the bench monitor
  task automatic rd_reg(input logic [3:0] a);
    @(posedge clk_in);
    addr_out <= a;
    rd_out   <= 1'b1;
    @(posedge clk_in);
    rd_out   <= 1'b0;
  endtask : rd_reg
  // wait ratio oversampling periods when gain stages are in use, then start
  task automatic start(input logic stages_on, input int ratio, input logic [7:0] div);
    // load the divider first so the wait is counted in real oversampling periods
    if (stages_on) wr_reg(ADDR_CTRL, {div, 8'h00});
    repeat (stages_on ? ratio * (div + 1) : 0) @(posedge clk_in);
    wr_reg(ADDR_CTRL, {div, 8'h01});
  endtask : start
endmodule : host_model

// ==== tb/adc_seq_checker.sv ====
// port checker for the conversion sequencer
// assumes it is bound into every sequencer instance
`timescale 1ns/100ps
module adc_seq_checker
  import adc_seq_pkg::*;
(
  input wire logic        ref_clk_in,
  input wire logic        rst_b_in,
  input wire logic [3:0]  addr_in,
  input wire logic [15:0] wdata_in,
  input wire logic        wr_in,
  input wire logic        rd_in,
  input wire logic [15:0] rdata_out,
  input wire logic        gain_reset_out,
  input wire logic        busy_out,
  input wire logic        ready_out,
  input wire logic [2:0]  amp_bias_qtr_out,
  input wire logic [2:0]  conv_bias_qtr_out,
  input wire logic [4:0]  resolution_out,
  input wire logic [2:0]  stage_en_out
);
  logic [7:0]  div;        // tracked divider value
  logic [2:0]  oc;         // tracked ratio code
  logic [1:0]  nc;         // tracked count code
  logic [31:0] bcnt, rcnt; // busy and ready run lengths
  int          nt;         // expected conversion length in clocks
  // shadow the settings and count run lengths
  always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      div  <= DIV_RST;
      oc   <= 3'h0;
      nc   <= 2'h0;
      bcnt <= 32'h0;
      rcnt <= 32'h0;
    end else begin
      if (wr_in && addr_in == ADDR_CTRL) div <= wdata_in[15:8];
      if (wr_in && addr_in == ADDR_CFG1) oc <= wdata_in[2:0];
      if (wr_in && addr_in == ADDR_CFG1) nc <= wdata_in[5:4];
      bcnt <= busy_out ? bcnt + 32'h1 : 32'h0;
      rcnt <= ready_out ? rcnt + 32'h1 : 32'h0;
    end
  end
  assign nt = ((1 << nc) * ((8 << oc) + 1) + 1) * (div + 1);
  default clocking cb @(posedge ref_clk_in); endclocking
  default disable iff (!rst_b_in);
  property p_grst; wr_in && addr_in <= ADDR_CFG5 |=> gain_reset_out; endproperty
  a_grst: assert property (p_grst) else $error("gain reset missing");
  property p_gonly; gain_reset_out |-> $past(wr_in) && $past(addr_in) <= ADDR_CFG5; endproperty
  a_gonly: assert property (p_gonly) else $error("stray gain reset");
  // bias and resolution outputs follow the stored word one clock after it lands
  property p_amp; wr_in && addr_in == ADDR_CFG2 |=> ##1
    amp_bias_qtr_out == 3'($past(wdata_in[1:0], 2)) + 3'h1; endproperty
  a_amp: assert property (p_amp) else $error("amp bias wrong");
  property p_conv; wr_in && addr_in == ADDR_CFG2 |=> ##1
    conv_bias_qtr_out == 3'($past(wdata_in[3:2], 2)) + 3'h1; endproperty
  a_conv: assert property (p_conv) else $error("converter bias wrong");
  property p_res; wr_in && addr_in == ADDR_CFG1 |=> ##1
    resolution_out == 5'(6 + 2 * $past(wdata_in[2:0], 2) + $past(wdata_in[5:4], 2)); endproperty
  a_res: assert property (p_res) else $error("resolution wrong");
  property p_start; wr_in && addr_in == ADDR_CTRL && wdata_in[START_BIT] && !busy_out
    && !ready_out |=> busy_out; endproperty
  a_start: assert property (p_start) else $error("start not taken");
  property p_len; $rose(ready_out) |-> $fell(busy_out) && bcnt + 4 >= nt && bcnt <= nt + 4;
  endproperty
  a_len: assert property (p_len) else $error("conversion length wrong");
  property p_width; $fell(ready_out) |-> rcnt == div + 1; endproperty
  a_width: assert property (p_width) else $error("ready width wrong");
  c_conv: cover property ($rose(ready_out));
  c_refuse: cover property (busy_out && wr_in && addr_in == ADDR_CTRL);
  c_grst: cover property (gain_reset_out);
endmodule : adc_seq_checker
bind oversampling_adc_sequencer adc_seq_checker u_chk (.ref_clk_in(ref_clk_in),
  .rst_b_in(rst_b_in), .addr_in(addr_in), .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in),
  .rdata_out(rdata_out), .gain_reset_out(gain_reset_out), .busy_out(busy_out),
  .ready_out(ready_out), .amp_bias_qtr_out(amp_bias_qtr_out), .stage_en_out(stage_en_out),
  .conv_bias_qtr_out(conv_bias_qtr_out), .resolution_out(resolution_out));

// ==== tb/oversampling_adc_sequencer_tb.sv ====
// self-checking bench for the conversion sequencer
// assumes host_model drives the register port and the checker is bound
`timescale 1ns/100ps
module oversampling_adc_sequencer_tb;
  import adc_seq_pkg::*;
  logic        ref_clk_in, rst_b_in, wr_in, rd_in, gain_reset_out, busy_out, ready_out;
  logic [3:0]  addr_in;
  logic [15:0] wdata_in, rdata_out, v;
  logic [2:0]  amp_bias_qtr_out, conv_bias_qtr_out, stage_en_out, oc;
  logic [4:0]  resolution_out;
  logic [1:0]  nc;
  logic [15:0] exp_q[$];    // expected read data, oldest first
  logic        rd_d = 1'b0; // a read was taken at the previous edge
  int          miscompares = 0, tests_run = 0, n, seed = 32'h7e5ef4a8;
  oversampling_adc_sequencer DUT (.ref_clk_in(ref_clk_in), .rst_b_in(rst_b_in),
    .addr_in(addr_in), .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in),
    .rdata_out(rdata_out), .gain_reset_out(gain_reset_out), .busy_out(busy_out),
    .ready_out(ready_out), .amp_bias_qtr_out(amp_bias_qtr_out), .stage_en_out(stage_en_out),
    .conv_bias_qtr_out(conv_bias_qtr_out), .resolution_out(resolution_out));
  host_model host (.clk_in(ref_clk_in), .addr_out(addr_in), .wdata_out(wdata_in),
    .wr_out(wr_in), .rd_out(rd_in));
  initial begin
    ref_clk_in = 1'b0;
    forever #12.5 ref_clk_in = ~ref_clk_in;
  end
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    tests_run++;
    if (got !== exp) begin
      miscompares++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  // note the expected word, then issue the read
  task automatic rd(input logic [3:0] a, input logic [15:0] e);
    exp_q.push_back(e);
    host.rd_reg(a);
  endtask : rd
  // read data stand in the cycle after the strobe
  always @(posedge ref_clk_in) begin
    if (rd_d === 1'b1) chk(rdata_out, exp_q.pop_front());
    rd_d = rd_in;
  end
  task automatic print_verdict();
    $display("comparisons %0d mismatches %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : print_verdict
  // the whole run takes well under a thousand cycles
  initial begin
    #(25 * 4000);
    miscompares++;
    print_verdict();
  end
  initial begin
    rst_b_in = 1'b0;
    repeat (10) @(posedge ref_clk_in);
    rst_b_in <= 1'b1;
    @(negedge ref_clk_in);
    chk(16'({amp_bias_qtr_out, conv_bias_qtr_out, resolution_out, busy_out, ready_out,
      gain_reset_out}), 16'({3'h4, 3'h4, 5'h06, 3'h0}));
    $display("reset test done");
    // every bias code on both selects, opposite orders
    for (int i = 0; i < 4; i++) begin
      host.wr_reg(ADDR_CFG2, 16'(i | ((3 - i) << 2)));
      @(negedge ref_clk_in);
      chk({15'h0, gain_reset_out}, 16'h1);
      // bias outputs are decoded from the stored word, one clock behind it
      @(negedge ref_clk_in);
      chk({10'h000, amp_bias_qtr_out, conv_bias_qtr_out}, 16'(((i + 1) << 3) | (4 - i)));
    end
    $display("bias test done");
    // random ratio and count codes, last one at the top of both ranges
    for (int i = 0; i < 4; i++) begin
      oc = (i == 3) ? 3'h7 : 3'($random(seed));
      nc = (i == 3) ? 2'h3 : 2'($random(seed));
      host.wr_reg(ADDR_CFG1, {10'h0, nc, 1'b0, oc});
      rd(ADDR_STATUS, {9'h0, 5'(6 + 2 * oc + nc), 2'b10});
    end
    v = 16'($random(seed)) & 16'h00FF;
    host.wr_reg(ADDR_CFG4, v);
    rd(ADDR_CFG4, v);
    rd(4'hF, 16'h0000);
    $display("resolution test done");
    // ratio 8, count 2: 19 periods of 8 clocks; first with stages, then bypassed
    host.wr_reg(ADDR_CFG1, 16'h0010);
    for (int i = 0; i < 2; i++) begin
      host.wr_reg(ADDR_CFG3, (i == 0) ? 16'h0007 : 16'h0000);
      // right after the write the settle delay has not run out unless bypassed
      rd(ADDR_STATUS, {9'h0, 5'h07, (i == 0) ? 2'b00 : 2'b10});
      host.start(i == 0, 8, 8'h07);
      @(negedge ref_clk_in);
      chk({15'h0, busy_out}, 16'h1);
      chk({13'h0, stage_en_out}, (i == 0) ? 16'h0007 : 16'h0000);
      host.start(1'b0, 8, 8'h07); // refused while busy
      n = 0;
      while (ready_out !== 1'b1 && n < 400) begin
        @(negedge ref_clk_in);
        n++;
      end
      chk(16'(n >= 146 && n <= 156), 16'h1);
      chk({15'h0, busy_out}, 16'h0);
      n = 0;
      while (ready_out === 1'b1 && n < 50) begin
        @(negedge ref_clk_in);
        n++;
      end
      chk(16'(n), 16'h0008);
    end
    $display("conversion test done");
    print_verdict();
  end
endmodule : oversampling_adc_sequencer_tb
